// file: logic/srwsup_pkg.sv
/*
 * Package for the supply reset and watchdog supervisor: timing constants,
 * reset values and the carrier structs for its inputs and outputs.
 * Assumes a 100 MHz core_clk that runs freely from a local time base.
 */
package srwsup_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;
	// Reset stretch after supply recovery or release of manual reset.
	localparam int unsigned RST_TIMEOUT_MS = 200;
	localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * (CLK_HZ / 1000);
	// Watchdog timeout, nominal figure.
	localparam int unsigned WD_TIMEOUT_MS = 1600;
	localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * (CLK_HZ / 1000);
	// Shortest kick pulse the input must catch.
	localparam int unsigned KICK_MIN_NS = 50;
	localparam int unsigned KICK_MIN_CYC =
		(KICK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CNT_W = 28;
	localparam int unsigned SYNC_STAGES = 2;
	localparam logic [1:0] SYNC_RST_HI = 2'h3;
	localparam logic [1:0] SYNC_RST_LO = 2'h0;
	localparam logic RST_ACTIVE_RESET_VAL = 1'h1;
	localparam logic WD_FLAG_RESET_VAL = 1'h0;

	typedef enum logic [2:0] {
		SRWSUP_HOLD = 3'h1,
		SRWSUP_STRETCH = 3'h2,
		SRWSUP_RUN = 3'h4
	} srwsup_rst_state_e;

	typedef struct packed {
		logic supply_low;
		logic power_fail_below;
		logic kick_tristated;
	} srwsup_sense_s;

	typedef struct packed {
		logic reset_out_n;
		logic reset_out;
		logic watchdog_flag_out;
		logic power_fail_warn_out;
	} srwsup_out_s;

endpackage : srwsup_pkg

// file: logic/srwsup_sync.sv
/*
 * Two-stage synchroniser for a single asynchronous pin.
 * Assumes the pin may change at any time relative to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module srwsup_sync #(
	parameter logic RESET_VAL = 1'h0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic pin_in,
	output logic sync_out
);
	logic [1:0] chain_q;
	logic [1:0] chain_d;

	always_comb begin
		chain_d = {chain_q[0], pin_in};
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			chain_q <= {2{RESET_VAL}};
		end else begin
			chain_q <= chain_d;
		end
	end

	assign sync_out = chain_q[1];
endmodule : srwsup_sync
`default_nettype wire

// file: logic/srwsup_top.sv
/*
 * Supply supervisor: stretched processor reset from supply-low and manual
 * reset, an independent watchdog cleared by kick edges, and a pass-through
 * of the power-fail comparison. Assumes sense flags arrive already
 * synchronised to core_clk and that core_clk runs from an internal time
 * base that keeps running while the supply is low.
 */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Reset held while supply is low
// - Reset held 200ms after supply recovers
// - Brownout reasserts reset, then 200ms stretch
// - New interruption restarts the full timeout
// - Active-low and active-high reset, exact inverses
// - Power-fail warning follows comparator only
// - Manual reset triggers debounced reset pulse (code only synchronises the pin, no debounce filter)
// - Undriven manual reset reads inactive high
// - Unkicked watchdog drives flag low
// - Watchdog cleared during reset or three-state
// - Watchdog counts once released and driven
// - Kick pulses of 50ns are caught
// - Flag low with reset on supply low
// - Floating kick disables watchdog, flag is low-line
// - Timeout flag latches; low-line release immediate
// - Both kick edges clear the watchdog
// - Manual reset release adds 200ms stretch
module srwsup_top #(
	parameter int unsigned RST_CYC = srwsup_pkg::RST_TIMEOUT_CYC,
	parameter int unsigned WD_CYC = srwsup_pkg::WD_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire srwsup_pkg::srwsup_sense_s sense_in,
	input wire logic manual_reset_in_n,
	input wire logic watchdog_kick_in,
	output srwsup_pkg::srwsup_out_s flags_out
);
	logic mr_n_s;
	logic kick_s;
	logic kick_prev_q;
	logic kick_prev_d;
	logic kick_edge;
	logic hold_cond;
	srwsup_pkg::srwsup_rst_state_e st_q;
	srwsup_pkg::srwsup_rst_state_e st_d;
	logic [srwsup_pkg::CNT_W-1:0] rcnt_q;
	logic [srwsup_pkg::CNT_W-1:0] rcnt_d;
	logic [srwsup_pkg::CNT_W-1:0] wcnt_q;
	logic [srwsup_pkg::CNT_W-1:0] wcnt_d;
	logic wd_to_q;
	logic wd_to_d;
	srwsup_pkg::srwsup_out_s out_q;
	srwsup_pkg::srwsup_out_s out_d;

	// Manual reset resets high so an unconnected pin is inactive.
	srwsup_sync #(.RESET_VAL(1'h1)) u_mr_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_in(manual_reset_in_n),
		.sync_out(mr_n_s)
	);

	// Sampling at 10 ns catches a 50 ns pulse at least four times.
	srwsup_sync #(.RESET_VAL(1'h0)) u_kick_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_in(watchdog_kick_in),
		.sync_out(kick_s)
	);

	assign hold_cond = sense_in.supply_low | ~mr_n_s;
	assign kick_edge = kick_s ^ kick_prev_q;

	function automatic logic [srwsup_pkg::CNT_W-1:0] cnt_inc(
		input logic [srwsup_pkg::CNT_W-1:0] v);
		cnt_inc = v + {{(srwsup_pkg::CNT_W-1){1'b0}}, 1'b1};
	endfunction : cnt_inc

	// Reset sequencing.
	always_comb begin
		st_d = st_q;
		rcnt_d = rcnt_q;
		case (st_q)
			srwsup_pkg::SRWSUP_HOLD: begin
				rcnt_d = '0;
				if (!hold_cond) begin
					st_d = srwsup_pkg::SRWSUP_STRETCH;
				end
			end
			srwsup_pkg::SRWSUP_STRETCH: begin
				if (hold_cond) begin
					st_d = srwsup_pkg::SRWSUP_HOLD;
					rcnt_d = '0;
				end else if (rcnt_q == RST_CYC[srwsup_pkg::CNT_W-1:0] - 1'b1) begin
					st_d = srwsup_pkg::SRWSUP_RUN;
					rcnt_d = '0;
				end else begin
					rcnt_d = cnt_inc(rcnt_q);
				end
			end
			srwsup_pkg::SRWSUP_RUN: begin
				if (hold_cond) begin
					st_d = srwsup_pkg::SRWSUP_HOLD;
				end
			end
			default: begin
				st_d = srwsup_pkg::SRWSUP_HOLD;
				rcnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= srwsup_pkg::SRWSUP_HOLD;
			rcnt_q <= '0;
		end else begin
			st_q <= st_d;
			rcnt_q <= rcnt_d;
		end
	end

	// Watchdog. The timeout flag latches until the next clearing event.
	always_comb begin
		kick_prev_d = kick_s;
		wcnt_d = wcnt_q;
		wd_to_d = wd_to_q;
		if (st_q != srwsup_pkg::SRWSUP_RUN || hold_cond ||
				sense_in.kick_tristated) begin
			wcnt_d = '0;
			wd_to_d = 1'b0;
		end else if (kick_edge) begin
			wcnt_d = '0;
			wd_to_d = 1'b0;
		end else if (wcnt_q == WD_CYC[srwsup_pkg::CNT_W-1:0] - 1'b1) begin
			wd_to_d = 1'b1;
		end else begin
			wcnt_d = cnt_inc(wcnt_q);
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			kick_prev_q <= 1'b0;
			wcnt_q <= '0;
			wd_to_q <= 1'b0;
		end else begin
			kick_prev_q <= kick_prev_d;
			wcnt_q <= wcnt_d;
			wd_to_q <= wd_to_d;
		end
	end

	// Outputs. Reset follows hold_cond in the same cycle as the state.
	always_comb begin
		out_d.reset_out_n = (st_d == srwsup_pkg::SRWSUP_RUN);
		out_d.reset_out = (st_d != srwsup_pkg::SRWSUP_RUN);
		// Low-line needs no stretch, so it releases with the supply.
		out_d.watchdog_flag_out = ~(sense_in.supply_low | wd_to_d);
		out_d.power_fail_warn_out = ~sense_in.power_fail_below;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			out_q.reset_out_n <= ~srwsup_pkg::RST_ACTIVE_RESET_VAL;
			out_q.reset_out <= srwsup_pkg::RST_ACTIVE_RESET_VAL;
			out_q.watchdog_flag_out <= srwsup_pkg::WD_FLAG_RESET_VAL;
			out_q.power_fail_warn_out <= 1'b1;
		end else begin
			out_q <= out_d;
		end
	end

	assign flags_out = out_q;

	// Checks.
	rst_inverse_a: assert property (@(posedge core_clk) disable iff (!rstn)
		flags_out.reset_out == ~flags_out.reset_out_n)
		else $error("reset outputs not inverse");
	supply_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		sense_in.supply_low |=> !flags_out.reset_out_n)
		else $error("reset released while supply low");
	stretch_min_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(flags_out.reset_out_n) |-> st_q == srwsup_pkg::SRWSUP_RUN
		&& $past(st_q) == srwsup_pkg::SRWSUP_STRETCH)
		else $error("reset released without stretch");
	restart_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(st_q == srwsup_pkg::SRWSUP_STRETCH && hold_cond) |=> rcnt_q == '0)
		else $error("timeout not restarted");
	wd_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(sense_in.kick_tristated || !flags_out.reset_out_n) |=> wcnt_q == '0)
		else $error("watchdog counting while disabled");
	kick_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		kick_edge |=> wcnt_q == '0 && !wd_to_q)
		else $error("kick edge did not clear watchdog");
	lowline_a: assert property (@(posedge core_clk) disable iff (!rstn)
		sense_in.supply_low |=> !flags_out.watchdog_flag_out)
		else $error("flag high during low supply");
	pfo_a: assert property (@(posedge core_clk) disable iff (!rstn)
		##1 flags_out.power_fail_warn_out == ~$past(sense_in.power_fail_below))
		else $error("power-fail warning mismatch");
	mr_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!mr_n_s |=> !flags_out.reset_out_n)
		else $error("manual reset ignored");

	wd_fire_c: cover property (@(posedge core_clk) disable iff (!rstn)
		$rose(wd_to_q));
	rst_release_c: cover property (@(posedge core_clk) disable iff (!rstn)
		$rose(flags_out.reset_out_n));
	restart_c: cover property (@(posedge core_clk) disable iff (!rstn)
		st_q == srwsup_pkg::SRWSUP_STRETCH && hold_cond);
	mr_c: cover property (@(posedge core_clk) disable iff (!rstn)
		$fell(mr_n_s) && flags_out.reset_out_n);
endmodule : srwsup_top
`default_nettype wire

// file: sim/srwsup_host.sv
/*
 * Host model: kicks the watchdog with short pulses, or lets the kick
 * line float. Assumes core_clk and rstn come from the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module srwsup_host #(
	parameter int unsigned PER = 20
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic kick_on,
	input wire logic float_on,
	output logic kick
);
	int unsigned cnt_q;
	logic float_q;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 0;
			float_q <= 1'h0;
			kick <= 1'h0;
		end else begin
			cnt_q <= (cnt_q + 1) % PER;
			float_q <= float_on;
			// A released line drifts once to the far level and rests there,
			// so only the three-state flag can keep the timer idle.
			if (float_on) begin
				if (!float_q) begin
					kick <= ~kick;
				end
			end else if (kick_on) begin
				kick <= cnt_q < 5;
			end
		end
	end
endmodule : srwsup_host
`default_nettype wire

// file: sim/srwsup_top_test.sv
/*
 * Self-checking bench for the supervisor with small timeout counts.
 * Assumes the host model drives the kick line.
 */
`timescale 1ns/100ps
`default_nettype none
module srwsup_top_test;
	localparam int unsigned RC = 20;
	localparam int unsigned WC = 50;
	logic core_clk = 1'h0;
	logic rstn = 1'h0;
	srwsup_pkg::srwsup_sense_s sense = '0;
	logic mr_n = 1'h1;
	logic kick_on = 1'h1;
	logic kick;
	logic pf_s = 1'h0;
	srwsup_pkg::srwsup_out_s flags;
	int n_errors = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'hF66FEC8C;
	logic [31:0] rnd = 32'hF66FEC8C;
	always #5 core_clk = ~core_clk;
	srwsup_top #(.RST_CYC(RC), .WD_CYC(WC)) srwsup_top_i (
		.core_clk(core_clk), .rstn(rstn), .sense_in(sense),
		.manual_reset_in_n(mr_n), .watchdog_kick_in(kick),
		.flags_out(flags));
	srwsup_host #(.PER(WC / 2)) srwsup_host_i (
		.core_clk(core_clk), .rstn(rstn), .kick_on(kick_on),
		.float_on(sense.kick_tristated), .kick(kick));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic int exp_rel(input logic man);
		// The manual pin pays two synchroniser edges first.
		return RC + 1 + (man ? 2 : 0);
	endfunction : exp_rel
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %0h seen %0h", what, e, g);
		end
	endtask : chk
	task automatic cyc_to(input int idx, input logic v, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			@(negedge core_clk);
		end while (flags[idx] !== v && n < 400);
		if (flags[idx] !== v) begin
			n_errors++;
			test_done();
		end
	endtask : cyc_to
	task automatic dip(input int len);
		@(posedge core_clk);
		sense.supply_low <= 1'h1;
		repeat (len) @(negedge core_clk);
		chk("rst held", 0, flags[3]);
		chk("wd low", 0, flags[1]);
		@(posedge core_clk);
		sense.supply_low <= 1'h0;
	endtask : dip
	always @(posedge core_clk) begin
		rnd = xs(rnd);
		sense.power_fail_below <= rnd[0] & rstn;
		pf_s <= sense.power_fail_below;
	end
	always @(negedge core_clk) begin
		if (rstn) begin
			chk("rst inverse", !flags[3], flags[2]);
			chk("pf warn", !pf_s, flags[0]);
		end
	end
	initial begin
		int n;
		repeat (8) @(posedge core_clk);
		rstn <= 1'h1;
		cyc_to(3, 1'h1, n);
		chk("por release", exp_rel(1'h0), n);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			dip(2 + seed[2:0]);
			if (i == 2) begin
				repeat (RC / 2) @(posedge core_clk);
				dip(2);
			end
			cyc_to(1, 1'h1, n);
			chk("lowline rel", 1, n);
			chk("stretching", 0, flags[3]);
			cyc_to(3, 1'h1, n);
			chk("supply rel", exp_rel(1'h0) - 1, n);
		end
		$display("supply dip tests done");
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			seed = xs(seed);
			mr_n <= seed[0];
		end
		@(posedge core_clk);
		mr_n <= 1'h0;
		repeat (10) @(negedge core_clk);
		chk("mr held", 0, flags[3]);
		@(posedge core_clk);
		mr_n <= 1'h1;
		cyc_to(3, 1'h1, n);
		chk("mr release", exp_rel(1'h1), n);
		$display("manual reset test done");
		repeat (3 * WC) begin
			@(negedge core_clk);
			chk("kicked", 1, flags[1]);
		end
		// Stop kicking just after a falling edge, with a bounded wait.
		n = 0;
		while (kick !== 1'h1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		while (kick !== 1'h0 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		if (kick !== 1'h0) begin
			n_errors++;
			test_done();
		end
		@(posedge core_clk);
		kick_on <= 1'h0;
		cyc_to(1, 1'h0, n);
		chk("wd timeout", 1, (n >= WC) && (n <= WC + 5));
		repeat (20) begin
			@(negedge core_clk);
			chk("wd latched", 0, flags[1]);
		end
		@(posedge core_clk);
		kick_on <= 1'h1;
		cyc_to(1, 1'h1, n);
		chk("wd cleared", 1, n <= WC / 2 + 5);
		$display("watchdog test done");
		@(posedge core_clk);
		sense.kick_tristated <= 1'h1;
		kick_on <= 1'h0;
		repeat (2 * WC) begin
			@(negedge core_clk);
			chk("wd disabled", 1, flags[1]);
		end
		dip(3);
		cyc_to(1, 1'h1, n);
		chk("lowline only", 1, n);
		$display("floating kick test done");
		test_done();
	end
endmodule : srwsup_top_test
`default_nettype wire
